// *** iep_pkg.sv ***
// Package: register addresses, field positions, reset values, counts
// Assumes an 8-bit special-function-register space on the core side
package iep_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_MAIN_IRQ_ENABLE         = 8'hA8;
  localparam logic [7:0] ADDR_PORT_LINE_ENABLE        = 8'hE8;
  localparam logic [7:0] ADDR_MAIN_IRQ_PRIORITY       = 8'hB8;
  localparam logic [7:0] ADDR_PORT_LINE_PRIORITY      = 8'hF8;
  localparam logic [7:0] ADDR_PORT_LINE_POLARITY      = 8'hE9;
  localparam logic [7:0] ADDR_PORT_LINE_REQUEST_FLAGS = 8'hC0;
  // ----------------------------------------
  // Main register fields
  // ----------------------------------------
  localparam int BIT_GLOBAL_GATE  = 7;
  localparam int BIT_SERIAL_PORT  = 5;
  localparam int BIT_TIMER1       = 3;
  localparam int BIT_OUTSIDE1     = 2;
  localparam int BIT_TIMER0       = 1;
  localparam int BIT_OUTSIDE0     = 0;
  localparam logic [7:0] MAIN_ENABLE_MASK   = 8'hAF;
  localparam logic [7:0] MAIN_PRIORITY_MASK = 8'h2F;
  localparam logic [7:0] REG_RESET          = 8'h00;
  // ----------------------------------------
  // Source numbering, in polling order
  // ----------------------------------------
  localparam int NUM_SOURCES = 13;
  localparam logic [3:0] SRC_NONE = 4'hF;
  // Machine cycle length in clocks
  localparam logic [3:0] MACHINE_CYCLE_CLKS = 4'hC;
endpackage

// *** iep_line_detect.sv ***
// Level detector for the eight port-line interrupts
// Assumes machine-cycle strobe from the core and synchronous pin levels
`timescale 1ns/1ns
module iep_line_detect (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       mc_tick,
  input  wire logic [7:0] port_lines,
  input  wire logic [7:0] port_line_polarities,
  output logic      [7:0] line_request
);
  // ----------------------------------------
  // Per-line qualification
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_line
      logic active;
      logic held_reg;
      assign active = (port_lines[i] == port_line_polarities[i]);
      // Level must stay active over a whole machine cycle
      // Cleared on reset, so no request before one whole cycle is seen
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          held_reg <= 1'b0;
        end else if (mc_tick) begin
          held_reg <= 1'b1;
        end else if (!active) begin
          held_reg <= 1'b0;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          line_request[i] <= 1'b0;
        end else begin
          line_request[i] <= mc_tick & held_reg & active;
        end
      end
    end
  endgenerate
endmodule

// *** iep_irq_ctrl.sv ***
// Interrupt enable, priority, polarity and request-flag registers
// Assumes the core gives a machine-cycle strobe and an SFR port
`timescale 1ns/1ns
module iep_irq_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       mc_tick,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  input  wire logic       outside_line0,
  input  wire logic       outside_line1,
  input  wire logic       timer0_req,
  input  wire logic       timer1_req,
  input  wire logic       two_wire_port,
  input  wire logic [7:0] port_lines,
  input  wire logic       irq_ack,
  input  wire logic       irq_return,
  output logic            irq_valid,
  output logic      [3:0] irq_source,
  output logic            irq_high
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] main_irq_enable_reg;
  logic [7:0] port_line_enable_reg;
  logic [7:0] main_irq_priority_reg;
  logic [7:0] port_line_priority_reg;
  logic [7:0] port_line_polarity_reg;
  logic [7:0] port_line_request_flags_reg;
  logic [7:0] line_request;
  logic       wr_me, wr_pe, wr_mp, wr_pp, wr_pol, wr_flg;

  assign wr_me  = sfr_wr &&
                  sfr_addr == iep_pkg::ADDR_MAIN_IRQ_ENABLE;
  assign wr_pe  = sfr_wr &&
                  sfr_addr == iep_pkg::ADDR_PORT_LINE_ENABLE;
  assign wr_mp  = sfr_wr &&
                  sfr_addr == iep_pkg::ADDR_MAIN_IRQ_PRIORITY;
  assign wr_pp  = sfr_wr &&
                  sfr_addr == iep_pkg::ADDR_PORT_LINE_PRIORITY;
  assign wr_pol = sfr_wr &&
                  sfr_addr == iep_pkg::ADDR_PORT_LINE_POLARITY;
  assign wr_flg = sfr_wr &&
                  sfr_addr == iep_pkg::ADDR_PORT_LINE_REQUEST_FLAGS;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_irq_enable_reg <= iep_pkg::REG_RESET;
    end else if (wr_me) begin
      main_irq_enable_reg <= sfr_wdata & iep_pkg::MAIN_ENABLE_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_irq_priority_reg <= iep_pkg::REG_RESET;
    end else if (wr_mp) begin
      main_irq_priority_reg <=
        sfr_wdata & iep_pkg::MAIN_PRIORITY_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_line_enable_reg   <= iep_pkg::REG_RESET;
      port_line_priority_reg <= iep_pkg::REG_RESET;
      port_line_polarity_reg <= iep_pkg::REG_RESET;
    end else begin
      if (wr_pe) begin
        port_line_enable_reg <= sfr_wdata;
      end
      if (wr_pp) begin
        port_line_priority_reg <= sfr_wdata;
      end
      if (wr_pol) begin
        port_line_polarity_reg <= sfr_wdata;
      end
    end
  end

  // Set wins over a same-cycle software clear, so no request is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_line_request_flags_reg <= iep_pkg::REG_RESET;
    end else begin
      port_line_request_flags_reg <=
        (wr_flg ? sfr_wdata : port_line_request_flags_reg)
        | (line_request & port_line_enable_reg);
    end
  end

  iep_line_detect u_detect (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .mc_tick              (mc_tick),
    .port_lines           (port_lines),
    .port_line_polarities (port_line_polarity_reg),
    .line_request         (line_request)
  );

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = 8'h00;
    unique case (sfr_addr)
      iep_pkg::ADDR_MAIN_IRQ_ENABLE:         sfr_rdata = main_irq_enable_reg;
      iep_pkg::ADDR_PORT_LINE_ENABLE:        sfr_rdata = port_line_enable_reg;
      iep_pkg::ADDR_MAIN_IRQ_PRIORITY:       sfr_rdata = main_irq_priority_reg;
      iep_pkg::ADDR_PORT_LINE_PRIORITY:      sfr_rdata = port_line_priority_reg;
      iep_pkg::ADDR_PORT_LINE_POLARITY:      sfr_rdata = port_line_polarity_reg;
      iep_pkg::ADDR_PORT_LINE_REQUEST_FLAGS:
        sfr_rdata = port_line_request_flags_reg;
      default:                               sfr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Arbitration, index = polling order
  // ----------------------------------------
  logic [12:0] pend;
  logic [12:0] lvl;
  logic [12:0] en;
  logic [7:0]  me;
  logic [7:0]  mp;
  logic [7:0]  pe;
  logic [7:0]  pp;
  logic [7:0]  fl;
  assign me = main_irq_enable_reg;
  assign mp = main_irq_priority_reg;
  assign pe = port_line_enable_reg;
  assign pp = port_line_priority_reg;
  assign fl = port_line_request_flags_reg;
  // Order: X0 S X5 T0 X6 X1 X2 X7 T1 X3 X8 X4 X9
  assign pend = {fl[7], fl[2], fl[6], fl[1], timer1_req, fl[5], fl[0],
                 outside_line1, fl[4], timer0_req, fl[3], two_wire_port,
                 outside_line0};
  assign en   = {pe[7], pe[2], pe[6], pe[1], me[iep_pkg::BIT_TIMER1], pe[5],
                 pe[0], me[iep_pkg::BIT_OUTSIDE1], pe[4],
                 me[iep_pkg::BIT_TIMER0], pe[3], me[iep_pkg::BIT_SERIAL_PORT],
                 me[iep_pkg::BIT_OUTSIDE0]};
  assign lvl  = {pp[7], pp[2], pp[6], pp[1], mp[iep_pkg::BIT_TIMER1], pp[5],
                 pp[0], mp[iep_pkg::BIT_OUTSIDE1], pp[4],
                 mp[iep_pkg::BIT_TIMER0], pp[3], mp[iep_pkg::BIT_SERIAL_PORT],
                 mp[iep_pkg::BIT_OUTSIDE0]};

  logic [12:0] live;
  logic [12:0] live_hi;
  logic [3:0]  pick_hi;
  logic [3:0]  pick_lo;
  assign live    = pend & en & {13{me[iep_pkg::BIT_GLOBAL_GATE]}};
  assign live_hi = live & lvl;

  always_comb begin
    pick_hi = iep_pkg::SRC_NONE;
    pick_lo = iep_pkg::SRC_NONE;
    for (int k = iep_pkg::NUM_SOURCES - 1; k >= 0; k--) begin
      if (live_hi[k]) begin
        pick_hi = 4'(k);
      end
      if (live[k] && !lvl[k]) begin
        pick_lo = 4'(k);
      end
    end
  end

  // ----------------------------------------
  // Nesting state
  // ----------------------------------------
  logic in_lo_reg;
  logic in_hi_reg;
  logic want_hi;
  logic want_lo;
  assign want_hi = pick_hi != iep_pkg::SRC_NONE && !in_hi_reg;
  assign want_lo = pick_lo != iep_pkg::SRC_NONE && !in_hi_reg && !in_lo_reg;

  // Return closes the innermost level first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_hi_reg <= 1'b0;
      in_lo_reg <= 1'b0;
    end else if (irq_ack && irq_valid) begin
      if (irq_high) begin
        in_hi_reg <= 1'b1;
      end else begin
        in_lo_reg <= 1'b1;
      end
    end else if (irq_return) begin
      if (in_hi_reg) begin
        in_hi_reg <= 1'b0;
      end else begin
        in_lo_reg <= 1'b0;
      end
    end
  end

  // Registered offer; port flags already lag one machine cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_valid  <= 1'b0;
      irq_source <= iep_pkg::SRC_NONE;
      irq_high   <= 1'b0;
    end else if (irq_ack && irq_valid) begin
      irq_valid  <= 1'b0;
      irq_source <= iep_pkg::SRC_NONE;
      irq_high   <= 1'b0;
    end else begin
      irq_valid  <= want_hi | want_lo;
      irq_source <= want_hi ? pick_hi
                    : (want_lo ? pick_lo : iep_pkg::SRC_NONE);
      irq_high   <= want_hi;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gate_blocks_a: assert property (@(posedge clk_sys) disable iff (rst)
    !main_irq_enable_reg[iep_pkg::BIT_GLOBAL_GATE] |=> !irq_valid)
    else $error("offer while global gate closed");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (main_irq_enable_reg[6] == 1'b0) && (main_irq_enable_reg[4] == 1'b0)
    && (main_irq_priority_reg[7:6] == 2'b00)
    && (main_irq_priority_reg[4] == 1'b0))
    else $error("reserved bit set");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_flg |=> (port_line_request_flags_reg
    & $past(port_line_request_flags_reg))
    == $past(port_line_request_flags_reg))
    else $error("flag cleared by hardware");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    |(line_request & port_line_enable_reg) |=>
    (port_line_request_flags_reg & $past(line_request & port_line_enable_reg))
    == $past(line_request & port_line_enable_reg))
    else $error("enabled request not flagged");
  no_hi_preempt_a: assert property (@(posedge clk_sys) disable iff (rst)
    in_hi_reg && !irq_return |=> !irq_valid)
    else $error("high service pre-empted");
  lo_needs_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
    in_lo_reg && irq_valid |-> irq_high)
    else $error("low service pre-empted by low");
  ena_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_pe |=> port_line_enable_reg == $past(sfr_wdata))
    else $error("line enable not stored");
  pol_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    sfr_addr == iep_pkg::ADDR_PORT_LINE_POLARITY
    |-> sfr_rdata == port_line_polarity_reg)
    else $error("polarity read wrong");
endmodule

// *** iep_core_model.sv ***
// Core-side model: machine-cycle strobe and request acknowledge
// Assumes the controller drops irq_valid the clock after irq_ack
`timescale 1ns/1ns
module iep_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ack_en,
  input  wire logic       irq_valid,
  input  wire logic [3:0] irq_source,
  output logic            mc_tick,
  output logic            irq_ack,
  output logic      [3:0] last_src
);
  // ----------------------------------------
  // Machine cycle and acknowledge
  // ----------------------------------------
  logic [3:0] cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (rst || cnt_reg == iep_pkg::MACHINE_CYCLE_CLKS - 4'h1) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign mc_tick = (cnt_reg == 4'h0) && !rst;
  // One ack per offer, held until the edge that takes it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_ack  <= 1'b0;
      last_src <= 4'hF;
    end else begin
      irq_ack <= ack_en && irq_valid && !irq_ack;
      if (irq_ack && irq_valid) begin
        last_src <= irq_source;
      end
    end
  end
endmodule

// *** iep_irq_ctrl_test.sv ***
// Testbench: register access, gating, polling order, port lines, nesting
// Assumes iep_core_model supplies mc_tick and irq_ack
`timescale 1ns/1ns
module iep_irq_ctrl_test;
  logic       clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, ack_en = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, port_lines = 8'hFF;
  logic [4:0] srcs = 5'h00;
  logic       irq_return = 1'b0, mc_tick, irq_ack, irq_valid, irq_high;
  logic [7:0] sfr_rdata;
  logic [3:0] irq_source, last_src;
  logic       sfr_hit;
  int         fails = 0, checks = 0, cyc = 0, i;
  logic [7:0] adr [6] = '{8'hA8, 8'hB8, 8'hC0, 8'hE8, 8'hE9, 8'hF8};
  logic [7:0] rbk [6] = '{8'hAF, 8'h2F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [3:0] ord [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h8};
  int         bit_of [5] = '{0, 4, 2, 1, 3};
  always #25 clk_sys = ~clk_sys;
  iep_irq_ctrl i_iep_irq_ctrl (.clk_sys(clk_sys), .rst(rst),
    .mc_tick(mc_tick), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .outside_line0(srcs[0]), .outside_line1(srcs[1]),
    .timer0_req(srcs[2]), .timer1_req(srcs[3]), .two_wire_port(srcs[4]),
    .port_lines(port_lines), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_valid(irq_valid), .irq_source(irq_source), .irq_high(irq_high));
  iep_core_model i_iep_core_model (.clk_sys(clk_sys), .rst(rst),
    .ack_en(ack_en), .irq_valid(irq_valid), .irq_source(irq_source),
    .mc_tick(mc_tick), .irq_ack(irq_ack), .last_src(last_src));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (exp !== got) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc_n(int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    #5;
    chk("sfr_rdata", exp, sfr_rdata);
  endtask
  task automatic offer(logic v, logic [3:0] s, logic h);
    cyc_n(3);
    chk("irq_valid", {7'h0, v}, {7'h0, irq_valid});
    if (v) begin
      chk("irq_source", {4'h0, s}, {4'h0, irq_source});
      chk("irq_high", {7'h0, h}, {7'h0, irq_high});
    end
    @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (i = 0; i < 6; i++) rd(adr[i], 8'h00);
    for (i = 0; i < 6; i++) wr(adr[i], 8'hFF);
    for (i = 0; i < 6; i++) rd(adr[i], rbk[i]);
    rd(8'h00, 8'h00);
    chk("sfr_hit", 8'h00, {7'h0, sfr_hit});
    wr(8'hE8, 8'h5A);
    rd(8'hE8, 8'h5A);
    chk("sfr_hit", 8'h01, {7'h0, sfr_hit});
  endtask
  task automatic t_gate();
    wr(8'hA8, 8'h01);
    srcs <= 5'h01;
    offer(1'b0, 4'h0, 1'b0);
    wr(8'hA8, 8'h81);
    offer(1'b1, 4'h0, 1'b0);
    wr(8'hA8, 8'h80);
    offer(1'b0, 4'h0, 1'b0);
  endtask
  task automatic t_order();
    wr(8'hA8, 8'hAF);
    srcs <= 5'h1F;
    for (i = 0; i < 5; i++) begin
      offer(1'b1, ord[i], 1'b0);
      srcs[bit_of[i]] <= 1'b0;
    end
    srcs <= 5'h1F;
    wr(8'hB8, 8'h08);
    offer(1'b1, 4'h8, 1'b1);
    srcs <= 5'h00;
  endtask
  task automatic t_port();
    wr(8'hE9, 8'h01);
    wr(8'hE8, 8'h01);
    port_lines <= 8'hFC;
    repeat (30) @(posedge clk_sys);
    port_lines <= 8'hFF;
    repeat (30) @(posedge clk_sys);
    rd(8'hC0, 8'h01);
    wr(8'hF8, 8'h01);
    wr(8'hA8, 8'h80);
    offer(1'b1, 4'h6, 1'b1);
    // Level requests re-set the flag, so drop the line before clearing
    port_lines <= 8'hFE;
    wr(8'hC0, 8'h00);
    rd(8'hC0, 8'h00);
    offer(1'b0, 4'h0, 1'b0);
  endtask
  task automatic t_nest();
    wr(8'hB8, 8'h06);
    wr(8'hA8, 8'h87);
    ack_en <= 1'b1;
    srcs   <= 5'h01;
    cyc_n(6);
    chk("last_src", 8'h00, {4'h0, last_src});
    @(posedge clk_sys);
    srcs <= 5'h04;
    cyc_n(6);
    chk("last_src", 8'h03, {4'h0, last_src});
    @(posedge clk_sys);
    srcs <= 5'h02;
    cyc_n(6);
    chk("last_src", 8'h03, {4'h0, last_src});
    @(posedge clk_sys);
    irq_return <= 1'b1;
    @(posedge clk_sys);
    irq_return <= 1'b0;
    cyc_n(6);
    chk("last_src", 8'h05, {4'h0, last_src});
    @(posedge clk_sys);
    srcs   <= 5'h00;
    ack_en <= 1'b0;
  endtask
  initial begin
    do_reset();
    t_regs();
    do_reset();
    t_gate();
    t_order();
    do_reset();
    t_port();
    do_reset();
    t_nest();
    report_and_stop();
  end
endmodule
